// ==== include/chain_regs_pkg.sv ====
// Contract
// - Role bit marks base or stacked unit
// - Role bit marks highest unit of stack
// - Wake tone bit sends tone, self-clears
// - Sleep-to-active bit sends tone, self-clears
// - Off state bit powers device off, self-clears
// - Sleep state bit sleeps device, self-clears
// - Reset bit resets logic, sends wake tone
// - Auto-address bit enables address writing
// - Reset, off, sleep; wake, s2a, hard order
// - Power commands override tones in one write
// - Hard reset tone bit clears on read
// - Host CRC bytes stored, reset 0x57/0x89
// - Computed CRC bytes are read-only
// - Temp window ready after round-robin pass
// - Volt window ready after round-robin pass
// - Protector self-test done cleared on start
// - Supply self-test done set, cleared on start
// - Aux ready flags set, cleared on rising start
// - Main ready set per pass, cleared on start
// - Filter ready cleared and restarted on inject
// - Comparison ready flags cleared on start
// - CRC complete bit set, cleared on read
package chain_regs_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam int IDX_W = 11;
	localparam logic [10:0] IDX_HOST_CRC_HIGH = 11'h036;
	localparam logic [10:0] IDX_HOST_CRC_LOW = 11'h037;
	localparam logic [10:0] IDX_CHAIN_ROLE = 11'h308;
	localparam logic [10:0] IDX_POWER_TONE = 11'h309;
	localparam logic [10:0] IDX_RESET_TONE_REF = 11'h30a;
	localparam logic [10:0] IDX_CALC_CRC_HIGH = 11'h50c;
	localparam logic [10:0] IDX_CALC_CRC_LOW = 11'h50d;
	localparam logic [10:0] IDX_DIAG_READY = 11'h526;
	localparam logic [10:0] IDX_CONV_READY = 11'h527;
	localparam logic [10:0] IDX_COMP_READY = 11'h528;
	localparam logic [10:0] IDX_DEVICE_STATUS = 11'h52c;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ROLE_STACK_BIT = 1;
	localparam int ROLE_TOP_BIT = 0;
	localparam int CMD_OFF_TONE_BIT = 6;
	localparam int CMD_WAKE_TONE_BIT = 5;
	localparam int CMD_S2A_TONE_BIT = 4;
	localparam int CMD_OFF_STATE_BIT = 3;
	localparam int CMD_SLEEP_STATE_BIT = 2;
	localparam int CMD_DIG_RESET_BIT = 1;
	localparam int CMD_AUTO_ADDR_BIT = 0;
	localparam int CTL2_HARD_TONE_BIT = 1;
	localparam int CTL2_TSREF_BIT = 0;
	localparam int DEV_CRC_DONE_BIT = 5;

	// Flag vector layout: [4:0] diag, [7:5] conv, [12:8] comp register bits 3:0 plus filter
	localparam int NUM_FLAGS = 13;
	localparam int FLG_DIAG_LSB = 0;
	localparam int FLG_CONV_LSB = 5;
	localparam int FLG_COMP_LSB = 8;
	localparam int FLG_FILTER = 12;
	localparam int COMP_FILTER_BIT = 5;

	// ----------------------------------------
	// Reset values and modes
	// ----------------------------------------
	localparam logic [7:0] HOST_CRC_HIGH_RST = 8'h57;
	localparam logic [7:0] HOST_CRC_LOW_RST = 8'h89;
	localparam logic [7:0] CALC_CRC_HIGH_RST = 8'h31;
	localparam logic [7:0] CALC_CRC_LOW_RST = 8'hf3;
	localparam logic [1:0] MODE_ROUND_ROBIN = 2'h1;
	localparam logic [1:0] MODE_SELFTEST = 2'h2;

	// Power request order: 0 digital reset, 1 off, 2 sleep
	// Tone request order: 0 wake, 1 sleep-to-active, 2 hard reset, 3 off
	localparam int NUM_POWER = 3;
	localparam int NUM_TONE = 4;

endpackage

// ==== hdl/flag_bank.sv ====
`timescale 1ns/1ps
module flag_bank #(
	parameter int N = 13
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [N-1:0] set_evt,
	input wire logic [N-1:0] clr_evt,
	output logic [N-1:0] flags
);

	typedef struct packed {
		logic [N-1:0] q;
	} bank_t;

	bank_t s_r;
	bank_t s_nxt;

	// A completion landing on the clearing cycle must not be lost
	always_comb begin
		s_nxt.q = (s_r.q & ~clr_evt) | set_evt;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign flags = s_r.q;

endmodule

// ==== hdl/command_arbiter.sv ====
`timescale 1ns/1ps
module command_arbiter import chain_regs_pkg::*; (
	input wire logic [NUM_POWER-1:0] power_req,
	input wire logic [NUM_TONE-1:0] tone_req,
	output logic [NUM_POWER-1:0] power_grant,
	output logic [NUM_TONE-1:0] tone_grant
);

	function automatic logic [3:0] first_one(input logic [3:0] req);
		logic [3:0] g;
		g = 4'h0;
		for (int i = 3; i >= 0; i--) begin
			if (req[i]) begin
				g = 4'h0;
				g[i] = 1'b1;
			end
		end
		return g;
	endfunction

	logic [3:0] pwr_pick;
	logic [3:0] tone_pick;

	always_comb begin
		pwr_pick = first_one({1'b0, power_req});
		tone_pick = first_one(tone_req);
		power_grant = pwr_pick[NUM_POWER-1:0];
		// Any power command suppresses every tone of the same write
		tone_grant = (|power_req) ? 4'h0 : tone_pick;
	end

endmodule

// ==== hdl/chain_control_status_regs.sv ====
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module chain_control_status_regs import chain_regs_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave, byte address
	input wire logic [12:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Chain role and mode levels
	output logic stack_unit,
	output logic highest_chain_unit,
	output logic auto_address_mode,
	output logic thermistor_ref_enable,
	// Tone and power command pulses
	output logic emit_off_tone,
	output logic emit_wake_tone,
	output logic emit_sleep_to_active_tone,
	output logic emit_hard_reset_tone,
	output logic enter_off_state,
	output logic enter_sleep_state,
	output logic digital_reset_request,
	// Customer CRC
	output logic [7:0] host_crc_high,
	output logic [7:0] host_crc_low,
	input wire logic crc_result_valid,
	input wire logic [15:0] crc_result,
	// Protector engines
	input wire logic temp_protector_go,
	input wire logic [1:0] temp_protector_mode,
	input wire logic temp_pass_done,
	input wire logic temp_selftest_end,
	input wire logic volt_protector_go,
	input wire logic [1:0] volt_protector_mode,
	input wire logic volt_pass_done,
	input wire logic volt_selftest_end,
	input wire logic supply_selftest_start,
	input wire logic supply_selftest_end,
	// Converters
	input wire logic aux_start,
	input wire logic aux_cell_pass_done,
	input wire logic aux_misc_pass_done,
	input wire logic main_start,
	input wire logic main_pass_done,
	input wire logic filter_fault_inject,
	input wire logic filter_checks_done,
	output logic filter_checks_restart,
	// Diagnostic comparison
	input wire logic comparison_start,
	input wire logic sense_open_wire_end,
	input wire logic balance_open_wire_end,
	input wire logic balance_switch_end,
	input wire logic cross_check_end
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic role_stack;
		logic role_top;
		logic auto_addr;
		logic hard_tone_bit;
		logic tsref;
		logic [7:0] host_hi;
		logic [7:0] host_lo;
		logic [7:0] calc_hi;
		logic [7:0] calc_lo;
		logic crc_done;
		logic aux_start_d;
		logic main_start_d;
		logic [NUM_TONE-1:0] tone_out;
		logic [NUM_POWER-1:0] power_out;
		logic filter_restart;
	} regs_t;

	regs_t s_r;
	regs_t s_nxt;

	function automatic logic hit(input logic [12:0] addr, input logic [10:0] idx);
		return addr[12:2] == idx;
	endfunction

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Every access takes exactly one wait cycle; writes and read side effects
	// land on the edge at which waitrequest is seen low.
	logic req;
	logic wr_go;
	logic rd_go;
	logic [7:0] wd;
	logic wr_cmd;

	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~s_r.ack;
	assign wr_go = avs_write & s_r.ack & avs_byteenable[0];
	assign rd_go = avs_read & s_r.ack;
	assign wd = avs_writedata[7:0];
	assign wr_cmd = wr_go & hit(avs_address, IDX_POWER_TONE);

	// ----------------------------------------
	// Command arbitration
	// ----------------------------------------
	logic [NUM_POWER-1:0] power_req;
	logic [NUM_TONE-1:0] tone_req;
	logic [NUM_POWER-1:0] power_grant;
	logic [NUM_TONE-1:0] tone_grant;
	logic hard_tone_wr;

	assign hard_tone_wr = wr_go & hit(avs_address, IDX_RESET_TONE_REF)
		& wd[CTL2_HARD_TONE_BIT];
	assign power_req = {wd[CMD_SLEEP_STATE_BIT], wd[CMD_OFF_STATE_BIT],
		wd[CMD_DIG_RESET_BIT]} & {NUM_POWER{wr_cmd}};
	assign tone_req = {wd[CMD_OFF_TONE_BIT] & wr_cmd, hard_tone_wr,
		wd[CMD_S2A_TONE_BIT] & wr_cmd, wd[CMD_WAKE_TONE_BIT] & wr_cmd};

	command_arbiter u_arb (
		.power_req(power_req),
		.tone_req(tone_req),
		.power_grant(power_grant),
		.tone_grant(tone_grant)
	);

	// ----------------------------------------
	// Ready flags
	// ----------------------------------------
	logic [NUM_FLAGS-1:0] flag_set;
	logic [NUM_FLAGS-1:0] flag_clr;
	logic [NUM_FLAGS-1:0] flags;
	logic temp_rr_go;
	logic temp_bist_go;
	logic volt_rr_go;
	logic volt_bist_go;
	logic aux_rise;
	logic main_rise;

	assign temp_rr_go = temp_protector_go & (temp_protector_mode == MODE_ROUND_ROBIN);
	assign temp_bist_go = temp_protector_go & (temp_protector_mode == MODE_SELFTEST);
	assign volt_rr_go = volt_protector_go & (volt_protector_mode == MODE_ROUND_ROBIN);
	assign volt_bist_go = volt_protector_go & (volt_protector_mode == MODE_SELFTEST);
	// Start levels come from engine logic on this clock, so no synchroniser
	assign aux_rise = aux_start & ~s_r.aux_start_d;
	assign main_rise = main_start & ~s_r.main_start_d;

	always_comb begin
		flag_set = '0;
		flag_clr = '0;
		flag_set[FLG_DIAG_LSB + 4] = temp_pass_done;
		flag_clr[FLG_DIAG_LSB + 4] = temp_rr_go;
		flag_set[FLG_DIAG_LSB + 3] = volt_pass_done;
		flag_clr[FLG_DIAG_LSB + 3] = volt_rr_go;
		flag_set[FLG_DIAG_LSB + 2] = temp_selftest_end;
		flag_clr[FLG_DIAG_LSB + 2] = temp_bist_go;
		flag_set[FLG_DIAG_LSB + 1] = volt_selftest_end;
		flag_clr[FLG_DIAG_LSB + 1] = volt_bist_go;
		flag_set[FLG_DIAG_LSB] = supply_selftest_end;
		flag_clr[FLG_DIAG_LSB] = supply_selftest_start;
		flag_set[FLG_CONV_LSB + 2] = aux_cell_pass_done;
		flag_clr[FLG_CONV_LSB + 2] = aux_rise;
		flag_set[FLG_CONV_LSB + 1] = aux_misc_pass_done;
		flag_clr[FLG_CONV_LSB + 1] = aux_rise;
		flag_set[FLG_CONV_LSB] = main_pass_done;
		flag_clr[FLG_CONV_LSB] = main_rise;
		flag_set[FLG_COMP_LSB + 3] = sense_open_wire_end;
		flag_set[FLG_COMP_LSB + 2] = balance_open_wire_end;
		flag_set[FLG_COMP_LSB + 1] = balance_switch_end;
		flag_set[FLG_COMP_LSB] = cross_check_end;
		flag_clr[FLG_COMP_LSB +: 4] = {4{comparison_start}};
		// A new main run or an injected fault clears filter ready; only the fault restarts the checks
		flag_set[FLG_FILTER] = filter_checks_done & ~filter_fault_inject;
		flag_clr[FLG_FILTER] = filter_fault_inject | main_rise;
	end

	flag_bank #(
		.N(NUM_FLAGS)
	) u_flags (
		.clk(clk),
		.sys_rst(sys_rst),
		.set_evt(flag_set),
		.clr_evt(flag_clr),
		.flags(flags)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = 8'h00;
		case (avs_address[12:2])
			IDX_HOST_CRC_HIGH: rd_byte = s_r.host_hi;
			IDX_HOST_CRC_LOW: rd_byte = s_r.host_lo;
			IDX_CHAIN_ROLE: begin
				rd_byte[ROLE_STACK_BIT] = s_r.role_stack;
				rd_byte[ROLE_TOP_BIT] = s_r.role_top;
			end
			// Command bits self-clear, so only the mode bit reads back
			IDX_POWER_TONE: rd_byte[CMD_AUTO_ADDR_BIT] = s_r.auto_addr;
			IDX_RESET_TONE_REF: begin
				rd_byte[CTL2_HARD_TONE_BIT] = s_r.hard_tone_bit;
				rd_byte[CTL2_TSREF_BIT] = s_r.tsref;
			end
			IDX_CALC_CRC_HIGH: rd_byte = s_r.calc_hi;
			IDX_CALC_CRC_LOW: rd_byte = s_r.calc_lo;
			IDX_DIAG_READY: rd_byte[4:0] = flags[FLG_DIAG_LSB +: 5];
			IDX_CONV_READY: rd_byte[2:0] = flags[FLG_CONV_LSB +: 3];
			IDX_COMP_READY: begin
				rd_byte[3:0] = flags[FLG_COMP_LSB +: 4];
				rd_byte[COMP_FILTER_BIT] = flags[FLG_FILTER];
			end
			IDX_DEVICE_STATUS: rd_byte[DEV_CRC_DONE_BIT] = s_r.crc_done;
			default: rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = req & ~s_r.ack;
		if (req & ~s_r.ack) begin
			s_nxt.rdata = {24'h00_0000, rd_byte};
		end
		s_nxt.aux_start_d = aux_start;
		s_nxt.main_start_d = main_start;
		s_nxt.filter_restart = filter_fault_inject;
		// Pulses last one cycle; of their command bits only the hard reset tone bit reads back as set
		s_nxt.power_out = power_grant;
		s_nxt.tone_out = tone_grant;
		// Digital reset also wakes the devices above
		s_nxt.tone_out[0] = tone_grant[0] | power_grant[0];
		if (wr_go) begin
			if (hit(avs_address, IDX_HOST_CRC_HIGH)) begin
				s_nxt.host_hi = wd;
			end
			if (hit(avs_address, IDX_HOST_CRC_LOW)) begin
				s_nxt.host_lo = wd;
			end
			if (hit(avs_address, IDX_CHAIN_ROLE)) begin
				s_nxt.role_stack = wd[ROLE_STACK_BIT];
				s_nxt.role_top = wd[ROLE_TOP_BIT];
			end
			if (wr_cmd) begin
				s_nxt.auto_addr = wd[CMD_AUTO_ADDR_BIT];
			end
			if (hit(avs_address, IDX_RESET_TONE_REF)) begin
				s_nxt.tsref = wd[CTL2_TSREF_BIT];
			end
		end
		// Clear-on-read acts after the data was captured; a new set wins
		if (rd_go & hit(avs_address, IDX_RESET_TONE_REF)) begin
			s_nxt.hard_tone_bit = 1'b0;
		end
		if (hard_tone_wr) begin
			s_nxt.hard_tone_bit = 1'b1;
		end
		if (rd_go & hit(avs_address, IDX_DEVICE_STATUS)) begin
			s_nxt.crc_done = 1'b0;
		end
		if (crc_result_valid) begin
			s_nxt.calc_hi = crc_result[15:8];
			s_nxt.calc_lo = crc_result[7:0];
			s_nxt.crc_done = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.host_hi <= HOST_CRC_HIGH_RST;
			s_r.host_lo <= HOST_CRC_LOW_RST;
			s_r.calc_hi <= CALC_CRC_HIGH_RST;
			s_r.calc_lo <= CALC_CRC_LOW_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avs_readdata = s_r.rdata;
	assign stack_unit = s_r.role_stack;
	assign highest_chain_unit = s_r.role_top;
	assign auto_address_mode = s_r.auto_addr;
	assign thermistor_ref_enable = s_r.tsref;
	assign host_crc_high = s_r.host_hi;
	assign host_crc_low = s_r.host_lo;
	assign emit_wake_tone = s_r.tone_out[0];
	assign emit_sleep_to_active_tone = s_r.tone_out[1];
	assign emit_hard_reset_tone = s_r.tone_out[2];
	assign emit_off_tone = s_r.tone_out[3];
	assign digital_reset_request = s_r.power_out[0];
	assign enter_off_state = s_r.power_out[1];
	assign enter_sleep_state = s_r.power_out[2];
	assign filter_checks_restart = s_r.filter_restart;

endmodule

// ==== dv/chain_regs_chk.sv ====
`timescale 1ns/1ps
module chain_regs_chk import chain_regs_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [12:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic stack_unit,
	input wire logic highest_chain_unit,
	input wire logic auto_address_mode,
	input wire logic emit_off_tone,
	input wire logic emit_wake_tone,
	input wire logic emit_sleep_to_active_tone,
	input wire logic emit_hard_reset_tone,
	input wire logic enter_off_state,
	input wire logic enter_sleep_state,
	input wire logic digital_reset_request,
	input wire logic [7:0] host_crc_high,
	input wire logic filter_fault_inject,
	input wire logic filter_checks_restart
);
	// ----
	// Write completion
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic wdone;
	logic [10:0] ix;
	logic [7:0] wd;
	assign wdone = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign ix = avs_address[12:2];
	assign wd = avs_writedata[7:0];
	sequence s_wr(logic [10:0] i);
		wdone && ix == i;
	endsequence
	sequence s_cmd(logic [7:0] v);
		s_wr(IDX_POWER_TONE) ##0 wd == v;
	endsequence
	a_off_tone: assert property (s_cmd(8'h40) |=> emit_off_tone ##1 !emit_off_tone)
		else $error("off tone pulse wrong");
	a_wake_tone: assert property (s_cmd(8'h20) |=> emit_wake_tone)
		else $error("wake tone missing");
	a_s2a_tone: assert property (s_cmd(8'h10) |=> emit_sleep_to_active_tone)
		else $error("sleep to active tone missing");
	a_off_state: assert property (s_cmd(8'h08) |=> enter_off_state)
		else $error("off state request missing");
	a_sleep_state: assert property (s_cmd(8'h04) |=> enter_sleep_state)
		else $error("sleep request missing");
	a_reset_wake: assert property (s_cmd(8'h02) |=> digital_reset_request && emit_wake_tone)
		else $error("reset without wake tone");
	a_power_first: assert property (s_wr(IDX_POWER_TONE) ##0 wd[3:1] != 3'h0 |=>
		!emit_off_tone && !emit_sleep_to_active_tone && emit_wake_tone == $past(wd[1]))
		else $error("tone fired beside power command");
	a_power_one: assert property ($onehot0({digital_reset_request, enter_off_state,
		enter_sleep_state})) else $error("two power requests");
	a_hard_tone: assert property (s_wr(IDX_RESET_TONE_REF) ##0 wd[1] |=> emit_hard_reset_tone)
		else $error("hard reset tone missing");
	a_role_bits: assert property (s_wr(IDX_CHAIN_ROLE) |=> stack_unit == $past(wd[1])
		&& highest_chain_unit == $past(wd[0])) else $error("role levels wrong");
	a_auto_addr: assert property (s_wr(IDX_POWER_TONE) |=> auto_address_mode == $past(wd[0]))
		else $error("auto address level wrong");
	a_host_crc: assert property (s_wr(IDX_HOST_CRC_HIGH) |=> host_crc_high == $past(wd))
		else $error("host crc output wrong");
	a_filter_restart: assert property (filter_fault_inject |=> filter_checks_restart)
		else $error("filter restart missing");
endmodule
bind chain_control_status_regs chain_regs_chk chk_u (.clk, .sys_rst, .avs_address, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .stack_unit, .highest_chain_unit,
	.auto_address_mode, .emit_off_tone, .emit_wake_tone, .emit_sleep_to_active_tone,
	.emit_hard_reset_tone, .enter_off_state, .enter_sleep_state, .digital_reset_request,
	.host_crc_high, .filter_fault_inject, .filter_checks_restart);

// ==== dv/stack_neighbour_model.sv ====
`timescale 1ns/1ps
module stack_neighbour_model (
	input wire logic clk,
	input wire logic clr,
	input wire logic [6:0] tones,
	output logic [6:0] seen
);
	// Tones are one-cycle pulses, so they are latched until the host side clears them
	always_ff @(posedge clk) begin
		if (clr) begin
			seen <= 7'h00;
		end else begin
			seen <= seen | tones;
		end
	end
endmodule

// ==== dv/chain_control_status_regs_tb.sv ====
`timescale 1ns/1ps
module chain_control_status_regs_tb import chain_regs_pkg::*;;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, clr, restart;
	logic [12:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable, be;
	logic stack_unit, top_unit, auto_addr, tsref;
	logic [6:0] tones, seen;
	logic [7:0] crc_hi, crc_lo, rd;
	logic [15:0] crc_result;
	logic [1:0] mode;
	logic [20:0] ev;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	chain_control_status_regs dut_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .stack_unit,
		.highest_chain_unit(top_unit), .auto_address_mode(auto_addr),
		.thermistor_ref_enable(tsref), .emit_off_tone(tones[0]), .emit_wake_tone(tones[1]),
		.emit_sleep_to_active_tone(tones[2]), .emit_hard_reset_tone(tones[3]),
		.enter_off_state(tones[4]), .enter_sleep_state(tones[5]),
		.digital_reset_request(tones[6]), .host_crc_high(crc_hi), .host_crc_low(crc_lo),
		.crc_result_valid(ev[20]), .crc_result, .temp_protector_go(ev[0]),
		.temp_protector_mode(mode), .temp_pass_done(ev[1]), .temp_selftest_end(ev[2]),
		.volt_protector_go(ev[3]), .volt_protector_mode(mode), .volt_pass_done(ev[4]),
		.volt_selftest_end(ev[5]), .supply_selftest_start(ev[6]),
		.supply_selftest_end(ev[7]), .aux_start(ev[8]), .aux_cell_pass_done(ev[9]),
		.aux_misc_pass_done(ev[10]), .main_start(ev[11]), .main_pass_done(ev[12]),
		.filter_fault_inject(ev[13]), .filter_checks_done(ev[14]),
		.filter_checks_restart(restart), .comparison_start(ev[15]),
		.sense_open_wire_end(ev[16]), .balance_open_wire_end(ev[17]),
		.balance_switch_end(ev[18]), .cross_check_end(ev[19]));
	stack_neighbour_model peer_u (.clk, .clr, .tones, .seen);
	// ----
	// Shared tasks
	// ----
	task end_of_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask
	task bus(input logic wr, input logic [10:0] idx, input logic [7:0] wd);
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= 32'(wd);
		avs_byteenable <= be;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rdchk(input string nm, input logic [10:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(nm, exp, rd);
	endtask
	task pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev[k] <= 1'b0;
	endtask
	// Neighbour sees {reset, sleep, off, hard, s2a, wake, off tone}
	task tone(input logic [10:0] idx, input logic [7:0] wd, input logic [6:0] exp);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		bus(1'b1, idx, wd);
		repeat (2) @(posedge clk);
		chk("tones", {1'b0, exp}, {1'b0, seen});
	endtask
	// ----
	// Scenarios
	// ----
	task t_reset;
		rdchk("crc_hi", IDX_HOST_CRC_HIGH, 8'h57);
		rdchk("crc_lo", IDX_HOST_CRC_LOW, 8'h89);
		rdchk("calc_hi", IDX_CALC_CRC_HIGH, 8'h31);
		rdchk("calc_lo", IDX_CALC_CRC_LOW, 8'hf3);
		rdchk("diag", IDX_DIAG_READY, 8'h00);
		rdchk("conv", IDX_CONV_READY, 8'h00);
		rdchk("comp", IDX_COMP_READY, 8'h00);
		rdchk("role", IDX_CHAIN_ROLE, 8'h00);
		$display("t_reset done");
	endtask
	task t_rw;
		bus(1'b1, IDX_CHAIN_ROLE, 8'h03);
		rdchk("role", IDX_CHAIN_ROLE, 8'h03);
		chk("stack", 8'h01, {7'h00, stack_unit});
		chk("top", 8'h01, {7'h00, top_unit});
		bus(1'b1, IDX_HOST_CRC_LOW, 8'ha5);
		rdchk("crc_lo", IDX_HOST_CRC_LOW, 8'ha5);
		chk("crc_lo_out", 8'ha5, crc_lo);
		bus(1'b1, IDX_CALC_CRC_LOW, 8'h00);
		rdchk("calc_lo", IDX_CALC_CRC_LOW, 8'hf3);
		be = 4'he;
		bus(1'b1, IDX_HOST_CRC_HIGH, 8'h11);
		be = 4'hf;
		rdchk("crc_hi", IDX_HOST_CRC_HIGH, 8'h57);
		bus(1'b1, IDX_HOST_CRC_HIGH, 8'h3c);
		rdchk("crc_hi", IDX_HOST_CRC_HIGH, 8'h3c);
		bus(1'b1, 11'h100, 8'hff);
		rdchk("unmapped", 11'h100, 8'h00);
		$display("t_rw done");
	endtask
	task automatic t_cmd;
		logic [7:0] cmd [11] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h0e, 8'h0c,
			8'h70, 8'h50, 8'h48};
		logic [6:0] exp [11] = '{7'h01, 7'h02, 7'h04, 7'h10, 7'h20, 7'h42, 7'h42, 7'h10,
			7'h02, 7'h04, 7'h10};
		for (int i = 0; i < 11; i++) begin
			tone(IDX_POWER_TONE, cmd[i], exp[i]);
		end
		rdchk("cmd", IDX_POWER_TONE, 8'h00);
		bus(1'b1, IDX_POWER_TONE, 8'h01);
		rdchk("cmd", IDX_POWER_TONE, 8'h01);
		chk("auto", 8'h01, {7'h00, auto_addr});
		bus(1'b1, IDX_POWER_TONE, 8'h00);
		tone(IDX_RESET_TONE_REF, 8'h03, 7'h08);
		rdchk("ctl2", IDX_RESET_TONE_REF, 8'h03);
		chk("tsref", 8'h01, {7'h00, tsref});
		rdchk("ctl2", IDX_RESET_TONE_REF, 8'h01);
		$display("t_cmd done");
	endtask
	task automatic t_flags;
		int sidx [13] = '{1, 4, 2, 5, 7, 9, 10, 12, 14, 16, 17, 18, 19};
		int cidx [13] = '{0, 3, 0, 3, 6, 8, 8, 11, 13, 15, 15, 15, 15};
		logic [1:0] md [13] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
			2'h0, 2'h0, 2'h0};
		logic [7:0] mask [13] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h04, 8'h02, 8'h01,
			8'h20, 8'h08, 8'h04, 8'h02, 8'h01};
		logic [10:0] ri;
		for (int i = 0; i < 13; i++) begin
			ri = (i < 5) ? IDX_DIAG_READY : (i < 8) ? IDX_CONV_READY : IDX_COMP_READY;
			mode <= md[i];
			pulse(sidx[i]);
			bus(1'b0, ri, 8'h00);
			chk("flag_set", mask[i], rd & mask[i]);
			pulse(cidx[i]);
			bus(1'b0, ri, 8'h00);
			chk("flag_clr", 8'h00, rd & mask[i]);
		end
		$display("t_flags done");
	endtask
	task t_crc;
		crc_result <= 16'h1234;
		pulse(20);
		rdchk("calc_hi", IDX_CALC_CRC_HIGH, 8'h12);
		rdchk("calc_lo", IDX_CALC_CRC_LOW, 8'h34);
		rdchk("crc_done", IDX_DEVICE_STATUS, 8'h20);
		rdchk("crc_done", IDX_DEVICE_STATUS, 8'h00);
		$display("t_crc done");
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test;
		end
	end
	initial begin
		sys_rst = 1'b1;
		{avs_read, avs_write, clr} = 3'h0;
		avs_address = 13'h0000;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
		be = 4'hf;
		ev = 21'h00_0000;
		mode = 2'h0;
		crc_result = 16'h0000;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset;
		t_rw;
		t_cmd;
		t_flags;
		t_crc;
		end_of_test;
	end
endmodule
